// file: pkg/tmrseg_consts.svh
// Offsets, field positions and reset values of the timer soft event generator
`ifndef TMRSEG_CONSTS_SVH
`define TMRSEG_CONSTS_SVH
// ================================================================
// Register byte offsets
`define TMRSEG_OFF_CTRL    8'h00
`define TMRSEG_OFF_MSK     8'h0C
`define TMRSEG_OFF_STS     8'h10
`define TMRSEG_OFF_TRIG    8'h14
`define TMRSEG_OFF_CNT     8'h24
`define TMRSEG_OFF_PSC     8'h28
`define TMRSEG_OFF_ARR     8'h2C
`define TMRSEG_OFF_CC1     8'h34
// ================================================================
// Event trigger bits, shared by status and mask; overcapture bit 9 is in status and mask only
`define TMRSEG_B_UPD       0
`define TMRSEG_B_CH1       1
`define TMRSEG_B_CTL       5
`define TMRSEG_B_BRK       7
`define TMRSEG_B_OVC       9
`define TMRSEG_TRIG_MASK   16'h00A3
`define TMRSEG_STS_MASK    16'h02A3
// ================================================================
// Control register fields
`define TMRSEG_C_MODE_LO   0
`define TMRSEG_C_MODE_HI   1
`define TMRSEG_C_USS       2
`define TMRSEG_C_UD        3
`define TMRSEG_C_CH1IN     4
`define TMRSEG_C_CH1DMA    5
`define TMRSEG_C_COMPL     6
`define TMRSEG_CTRL_MASK   16'h007F
// ================================================================
// Reset values
`define TMRSEG_RST_ZERO    16'h0000
`define TMRSEG_RST_ARR     16'hFFFF
`define TMRSEG_RD_ZERO     32'h0000_0000
`endif

// file: pkg/tmrseg_pkg.sv
// Types of the timer soft event generator
package tmrseg_pkg;
    // Counting modes; 2'b11 is illegal and counts up
    typedef enum logic [1:0] {
        TMRSEG_UP     = 2'b00,
        TMRSEG_DOWN   = 2'b01,
        TMRSEG_CENTER = 2'b10
    } tmrseg_mode_t;
endpackage

// file: pkg/tmrseg_core_if.sv
// Signals between the register block, prescaler and main counter
`timescale 1ns/100ps
`default_nettype none
interface tmrseg_core_if #(parameter int W = 16);
    import tmrseg_pkg::*;
    logic         tick;
    logic         reinit;
    logic         ovf;
    tmrseg_mode_t mode;
    logic [W-1:0] arr;
    logic [W-1:0] psc;
    logic [W-1:0] cnt;
    modport ctl (output reinit, mode, arr, psc, input tick, ovf, cnt);
    modport pre (input reinit, psc, output tick);
    modport ctr (input tick, reinit, mode, arr, output ovf, cnt);
endinterface
`default_nettype wire

// file: logic/tmrseg_prescaler.sv
// Prescaler: divides the clock by psc+1 into counter ticks
`timescale 1ns/100ps
`default_nettype none
module tmrseg_prescaler
    import tmrseg_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // Core link
    tmrseg_core_if.pre  io
);
    logic [W-1:0] pcnt_r;

    if (W < 2) begin : g_bad_w
        $error("tmrseg_prescaler: W must be at least 2");
    end

    // Tick at the end of each division period; none while reinit
    assign io.tick = (pcnt_r == io.psc) && !io.reinit;

    // Update clears the count only; the factor lives upstream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_r <= '0;
        end else if (io.reinit) begin
            pcnt_r <= '0;
        end else if (pcnt_r == io.psc) begin
            pcnt_r <= '0;
        end else begin
            pcnt_r <= pcnt_r + 1'b1;
        end
    end

    property p_psc_clr;
        @(posedge pclk) disable iff (!presetn)
        io.reinit |=> (pcnt_r == '0) && $stable(io.psc);
    endproperty
    a_psc_clr: assert property (p_psc_clr)
        else $error("prescaler count not cleared by update");
endmodule // tmrseg_prescaler
`default_nettype wire

// file: logic/tmrseg_counter.sv
// Main counter: up, down or centre-aligned, reinitialised on update
`timescale 1ns/100ps
`default_nettype none
module tmrseg_counter
    import tmrseg_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // Core link
    tmrseg_core_if.ctr  io
);
    logic [W-1:0] cnt_r;
    logic         fall_r;  // Centre mode descending half
    logic         at_top;
    logic         at_bot;

    if (W < 2) begin : g_bad_w
        $error("tmrseg_counter: W must be at least 2");
    end

    assign at_top = (cnt_r == io.arr);
    assign at_bot = (cnt_r == '0);
    assign io.cnt = cnt_r;

    // Wrap detection; reinit masks it so a forced update is not doubled
    always_comb begin
        io.ovf = 1'b0;
        if (io.tick && !io.reinit) begin
            unique case (io.mode)
                TMRSEG_DOWN:   io.ovf = at_bot;
                TMRSEG_CENTER: io.ovf = fall_r ? at_bot : at_top;
                default:       io.ovf = at_top;
            endcase
        end
    end

    // Count; reinit wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r  <= '0;
            fall_r <= 1'b0;
        end else if (io.reinit) begin
            fall_r <= 1'b0;
            if (io.mode == TMRSEG_DOWN) begin
                cnt_r <= io.arr;
            end else begin
                cnt_r <= '0;
            end
        end else if (io.tick) begin
            unique case (io.mode)
                TMRSEG_DOWN: begin
                    cnt_r <= at_bot ? io.arr : cnt_r - 1'b1;
                end
                TMRSEG_CENTER: begin
                    if (!fall_r && at_top) begin
                        fall_r <= 1'b1;
                        cnt_r  <= cnt_r - 1'b1;
                    end else if (fall_r && at_bot) begin
                        fall_r <= 1'b0;
                        cnt_r  <= cnt_r + 1'b1;
                    end else begin
                        cnt_r  <= fall_r ? cnt_r - 1'b1 : cnt_r + 1'b1;
                    end
                end
                default: begin
                    cnt_r <= at_top ? '0 : cnt_r + 1'b1;
                end
            endcase
        end
    end

    property p_reinit_dn;
        @(posedge pclk) disable iff (!presetn)
        io.reinit && io.mode == TMRSEG_DOWN |=> cnt_r == $past(io.arr);
    endproperty
    a_reinit_dn: assert property (p_reinit_dn)
        else $error("down count not loaded with reload value");

    property p_reinit_up;
        @(posedge pclk) disable iff (!presetn)
        io.reinit && io.mode != TMRSEG_DOWN |=> cnt_r == '0 && !fall_r;
    endproperty
    a_reinit_up: assert property (p_reinit_up)
        else $error("up or centre count not cleared by update");
endmodule // tmrseg_counter
`default_nettype wire

// file: logic/tmrseg_top.sv
// Timer soft event generator: APB registers, forced events and flags
//
// Functional notes
// - Writing one to bit 0 reinitialises the counter and emits update.
// - The force-update bit is set by software, cleared by hardware after use.
// - Any update clears the prescaler count and keeps its factor.
// - Counting down, an update loads the counter with the reload value.
// - Counting up or centre-aligned, a forced update clears the counter.
// - Writing one to bit 1 forces a channel 1 event; bit self-clears.
// - Output channel: forced event sets flag, interrupt and DMA when enabled.
// - Input channel: forced event captures the counter and sets the flag.
// - Forced capture with channel flag already set also sets overcapture.
// - Writing one to bit 5 forces a control update; bit self-clears.
// - Control update acts only when the channel has complementary outputs.
// - Writing one to bit 7 forces a break event; bit self-clears.
// - Forced update sets update flag only if source select and disable are zero.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tmrseg_consts.svh"
module tmrseg_top
    import tmrseg_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Timer core events
    output var  logic        irq,
    output var  logic        ch1_dma_req,
    output var  logic        update_evt,
    output var  logic        ctrl_update_evt,
    output var  logic        break_evt
);
    // ================================================================
    // Declarations
    logic [15:0]  ctrl_r;
    logic [15:0]  msk_r;
    logic [15:0]  sts_r;
    logic [15:0]  sts_nxt;
    logic [15:0]  trig_r;
    logic [W-1:0] psc_r;
    logic [W-1:0] arr_r;
    logic [W-1:0] cc1_r;
    logic [31:0]  prdata_r;
    logic [31:0]  rd_nxt;
    logic         pready_r;
    logic         pslverr_r;
    logic         err_nxt;
    logic         irq_r;
    logic         dma_r;
    logic         upd_evt_r;
    logic         cupd_evt_r;
    logic         brk_evt_r;
    logic         wr_en;
    logic         setup;
    logic         f_upd;
    logic         f_ch1;
    logic         f_ctl;
    logic         f_brk;
    logic         ch1_in;
    logic         upd_ok;
    logic         nat_upd;
    logic         cupd_ok;

    tmrseg_core_if #(.W(W)) core ();

    if (W < 2 || W > 16) begin : g_bad_w
        $error("tmrseg_top: W must lie in 2..16");
    end

    // ================================================================
    // Submodules
    tmrseg_prescaler #(.W(W)) u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .io      (core.pre)
    );

    tmrseg_counter #(.W(W)) u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .io      (core.ctr)
    );

    // ================================================================
    // Control decode
    assign f_upd   = trig_r[`TMRSEG_B_UPD];
    assign f_ch1   = trig_r[`TMRSEG_B_CH1];
    assign f_ctl   = trig_r[`TMRSEG_B_CTL];
    assign f_brk   = trig_r[`TMRSEG_B_BRK];
    assign ch1_in  = ctrl_r[`TMRSEG_C_CH1IN];
    // Update flag for forced updates only with no source filter or disable
    assign upd_ok  = !ctrl_r[`TMRSEG_C_USS] && !ctrl_r[`TMRSEG_C_UD];
    assign nat_upd = core.ovf && !ctrl_r[`TMRSEG_C_UD];
    // Control update has no target on a channel without complementary pair
    assign cupd_ok = ctrl_r[`TMRSEG_C_COMPL];

    // Forced update reinitialises counter and prescaler at once
    assign core.reinit = f_upd;
    assign core.mode   = tmrseg_mode_t'(ctrl_r[`TMRSEG_C_MODE_HI:`TMRSEG_C_MODE_LO]);
    assign core.arr    = arr_r;
    assign core.psc    = psc_r;

    // ================================================================
    // APB handshake
    // Setup cycle samples the request; pready is high in the first access
    // cycle, so each transfer takes two cycles with no added waits.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_r && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup;
        end
    end

    // Read mux and address check
    always_comb begin
        rd_nxt  = `TMRSEG_RD_ZERO;
        err_nxt = 1'b0;
        unique case (paddr)
            `TMRSEG_OFF_CTRL: rd_nxt[15:0] = ctrl_r;
            `TMRSEG_OFF_MSK:  rd_nxt[15:0] = msk_r;
            `TMRSEG_OFF_STS:  rd_nxt[15:0] = sts_r;
            `TMRSEG_OFF_TRIG: rd_nxt       = `TMRSEG_RD_ZERO;
            `TMRSEG_OFF_CNT:  rd_nxt[W-1:0] = core.cnt;
            `TMRSEG_OFF_PSC:  rd_nxt[W-1:0] = psc_r;
            `TMRSEG_OFF_ARR:  rd_nxt[W-1:0] = arr_r;
            `TMRSEG_OFF_CC1:  rd_nxt[W-1:0] = cc1_r;
            default:          err_nxt       = 1'b1;
        endcase
    end

    // Read data and error are latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= `TMRSEG_RD_ZERO;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? `TMRSEG_RD_ZERO : rd_nxt;
            pslverr_r <= err_nxt;
        end else if (pready_r) begin
            pslverr_r <= 1'b0;
        end
    end

    // ================================================================
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `TMRSEG_RST_ZERO;
            msk_r  <= `TMRSEG_RST_ZERO;
            psc_r  <= W'(`TMRSEG_RST_ZERO);
            arr_r  <= W'(`TMRSEG_RST_ARR);
        end else if (wr_en) begin
            unique case (paddr)
                `TMRSEG_OFF_CTRL: ctrl_r <= pwdata[15:0] & `TMRSEG_CTRL_MASK;
                `TMRSEG_OFF_MSK:  msk_r  <= pwdata[15:0] & `TMRSEG_STS_MASK;
                `TMRSEG_OFF_PSC:  psc_r  <= pwdata[W-1:0];
                `TMRSEG_OFF_ARR:  arr_r  <= pwdata[W-1:0];
                default: ;
            endcase
        end
    end

    // ================================================================
    // Event trigger register
    // A write sets only the defined bits; each bit lives one cycle and is
    // cleared by hardware in the cycle its action is carried out. Writes
    // cannot land on two adjacent edges, so no request is dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_r <= `TMRSEG_RST_ZERO;
        end else if (wr_en && paddr == `TMRSEG_OFF_TRIG) begin
            trig_r <= pwdata[15:0] & `TMRSEG_TRIG_MASK;
        end else begin
            trig_r <= `TMRSEG_RST_ZERO;
        end
    end

    // ================================================================
    // Channel 1 capture register
    // Software may load the compare value only in output mode; in input
    // mode a forced event copies the running count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc1_r <= W'(`TMRSEG_RST_ZERO);
        end else if (f_ch1 && ch1_in) begin
            cc1_r <= core.cnt;
        end else if (wr_en && paddr == `TMRSEG_OFF_CC1 && !ch1_in) begin
            cc1_r <= pwdata[W-1:0];
        end
    end

    // ================================================================
    // Status flags: write one clears, a new event in the same cycle wins
    always_comb begin
        sts_nxt = sts_r;
        if (wr_en && paddr == `TMRSEG_OFF_STS) begin
            sts_nxt = sts_r & ~(pwdata[15:0] & `TMRSEG_STS_MASK);
        end
        if ((f_upd && upd_ok) || nat_upd) begin
            sts_nxt[`TMRSEG_B_UPD] = 1'b1;
        end
        if (f_ch1) begin
            sts_nxt[`TMRSEG_B_CH1] = 1'b1;
            if (ch1_in && sts_r[`TMRSEG_B_CH1]) begin
                sts_nxt[`TMRSEG_B_OVC] = 1'b1;
            end
        end
        if (f_ctl && cupd_ok) begin
            sts_nxt[`TMRSEG_B_CTL] = 1'b1;
        end
        if (f_brk) begin
            sts_nxt[`TMRSEG_B_BRK] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_r <= `TMRSEG_RST_ZERO;
        end else begin
            sts_r <= sts_nxt;
        end
    end

    // ================================================================
    // Interrupt: level while any unmasked flag is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(sts_nxt & msk_r);
        end
    end

    // ================================================================
    // Event pulses to the timer core, one cycle each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_evt_r  <= 1'b0;
            dma_r      <= 1'b0;
            cupd_evt_r <= 1'b0;
            brk_evt_r  <= 1'b0;
        end else begin
            upd_evt_r  <= f_upd || nat_upd;
            dma_r      <= f_ch1 && ctrl_r[`TMRSEG_C_CH1DMA];
            cupd_evt_r <= f_ctl && cupd_ok;
            brk_evt_r  <= f_brk;
        end
    end

    // ================================================================
    // Outputs
    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign irq             = irq_r;
    assign ch1_dma_req     = dma_r;
    assign update_evt      = upd_evt_r;
    assign ctrl_update_evt = cupd_evt_r;
    assign break_evt       = brk_evt_r;

    // ================================================================
    // Assertions
    property p_upd_evt;
        @(posedge pclk) disable iff (!presetn)
        f_upd |=> update_evt && !f_upd;
    endproperty
    a_upd_evt: assert property (p_upd_evt)
        else $error("forced update gave no update pulse");

    property p_self_clr;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `TMRSEG_OFF_TRIG && pwdata[`TMRSEG_B_UPD]
        |=> f_upd ##1 !f_upd;
    endproperty
    a_self_clr: assert property (p_self_clr)
        else $error("force update bit not set then cleared");

    property p_uflag;
        @(posedge pclk) disable iff (!presetn)
        f_upd && upd_ok |=> sts_r[`TMRSEG_B_UPD];
    endproperty
    a_uflag: assert property (p_uflag)
        else $error("forced update did not set update flag");

    property p_ch1flag;
        @(posedge pclk) disable iff (!presetn)
        f_ch1 |=> sts_r[`TMRSEG_B_CH1] && !f_ch1;
    endproperty
    a_ch1flag: assert property (p_ch1flag)
        else $error("forced channel event did not set flag");

    property p_dma;
        @(posedge pclk) disable iff (!presetn)
        f_ch1 && ctrl_r[`TMRSEG_C_CH1DMA] |=> ch1_dma_req ##1 !ch1_dma_req;
    endproperty
    a_dma: assert property (p_dma)
        else $error("channel DMA request missing or too long");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        f_ch1 && msk_r[`TMRSEG_B_CH1] |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled channel event raised no interrupt");

    property p_cap;
        @(posedge pclk) disable iff (!presetn)
        f_ch1 && ch1_in |=> cc1_r == $past(core.cnt);
    endproperty
    a_cap: assert property (p_cap)
        else $error("forced capture did not store the count");

    property p_ovc;
        @(posedge pclk) disable iff (!presetn)
        f_ch1 && ch1_in && sts_r[`TMRSEG_B_CH1] |=> sts_r[`TMRSEG_B_OVC];
    endproperty
    a_ovc: assert property (p_ovc)
        else $error("repeat capture did not set overcapture");

    property p_ctl;
        @(posedge pclk) disable iff (!presetn)
        f_ctl |=> ctrl_update_evt == $past(cupd_ok);
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("control update pulse wrong for channel type");

    property p_brk;
        @(posedge pclk) disable iff (!presetn)
        f_brk |=> break_evt && sts_r[`TMRSEG_B_BRK];
    endproperty
    a_brk: assert property (p_brk)
        else $error("forced break gave no break event");

    property p_rd0;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `TMRSEG_OFF_TRIG
        |=> pready && prdata == `TMRSEG_RD_ZERO;
    endproperty
    a_rd0: assert property (p_rd0)
        else $error("trigger register read not zero");
endmodule // tmrseg_top
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking testbench of the timer soft event generator
`timescale 1ns/100ps
`default_nettype none
`include "tmrseg_consts.svh"
// ====
// Compare macro: counts every check, reports a mismatch at once
`define CHK(nm, ex, got) \
    compares++; \
    if ((got) !== (ex)) begin \
        num_errors++; \
        $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end
module tb_top;
    // ====
    // Design ports
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        ch1_dma_req;
    logic        update_evt;
    logic        ctrl_update_evt;
    logic        break_evt;
    // Bench bookkeeping
    int          num_errors;
    int          compares;
    int          cycles;
    logic [7:0]  n_upd;
    logic [7:0]  n_ctl;
    logic [7:0]  n_brk;
    logic [7:0]  n_dma;
    logic [31:0] rv;
    logic        re;

    tmrseg_top #(.W(16)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .ch1_dma_req(ch1_dma_req),
        .update_evt(update_evt), .ctrl_update_evt(ctrl_update_evt), .break_evt(break_evt)
    );

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Pulse counters: a count of exactly one also proves a one-cycle pulse
    always @(posedge pclk) begin
        if (update_evt === 1'b1) n_upd <= n_upd + 8'h01;
        if (ctrl_update_evt === 1'b1) n_ctl <= n_ctl + 8'h01;
        if (break_evt === 1'b1) n_brk <= n_brk + 8'h01;
        if (ch1_dma_req === 1'b1) n_dma <= n_dma + 8'h01;
    end

    // Watchdog: whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    // ====
    // Closing report
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, rv, re);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
        xfer(a, 1'b0, 32'h0000_0000, rv, re);
        `CHK(nm, ex, rv)
        `CHK("pslverr", 1'b0, re)
    endtask

    // Write the trigger register, then wait four edges for the event pulses
    task automatic fire(input logic [15:0] d);
        n_upd = 8'h00;
        n_ctl = 8'h00;
        n_brk = 8'h00;
        n_dma = 8'h00;
        wr(`TMRSEG_OFF_TRIG, {16'h0000, d});
        repeat (4) @(posedge pclk);
    endtask

    // ====
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {n_upd, n_ctl, n_brk, n_dma} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, write-only trigger reads zero, unmapped address
        rd_chk(`TMRSEG_OFF_CTRL, 32'h0000_0000, "ctrl");
        rd_chk(`TMRSEG_OFF_ARR, 32'h0000_FFFF, "arr");
        rd_chk(`TMRSEG_OFF_TRIG, 32'h0000_0000, "trig");
        xfer(8'h40, 1'b0, 32'h0000_0000, rv, re);
        `CHK("unmapped err", 1'b1, re)
        `CHK("unmapped data", 32'h0000_0000, rv)
        // Up mode: forced update clears a running counter and flags
        wr(`TMRSEG_OFF_PSC, 32'h0000_FFFF);
        fire(16'h0001);
        `CHK("upd pulse", 8'h01, n_upd)
        rd_chk(`TMRSEG_OFF_CNT, 32'h0000_0000, "cnt up");
        rd_chk(`TMRSEG_OFF_STS, 32'h0000_0001, "sts upd");
        rd_chk(`TMRSEG_OFF_TRIG, 32'h0000_0000, "trig clr");
        wr(`TMRSEG_OFF_STS, 32'h0000_02A3);
        // Down mode with source select, then with updates disabled
        wr(`TMRSEG_OFF_ARR, 32'h0000_1234);
        for (int i = 0; i < 2; i++) begin
            wr(`TMRSEG_OFF_CTRL, (i == 0) ? 32'h0000_0005 : 32'h0000_0009);
            fire(16'h0001);
            `CHK("upd gated", 8'h01, n_upd)
            rd_chk(`TMRSEG_OFF_CNT, 32'h0000_1234, "cnt down");
            rd_chk(`TMRSEG_OFF_STS, 32'h0000_0000, "sts gated");
        end
        // Channel 1 as output, interrupt and DMA enabled
        wr(`TMRSEG_OFF_MSK, 32'h0000_0002);
        wr(`TMRSEG_OFF_CTRL, 32'h0000_0021);
        fire(16'h0002);
        `CHK("dma out", 8'h01, n_dma)
        rd_chk(`TMRSEG_OFF_STS, 32'h0000_0002, "sts out");
        `CHK("irq out", 1'b1, irq)
        // Channel 1 as input with its flag still set: capture plus overcapture
        wr(`TMRSEG_OFF_CTRL, 32'h0000_0031);
        fire(16'h0002);
        `CHK("dma in", 8'h01, n_dma)
        rd_chk(`TMRSEG_OFF_CC1, 32'h0000_1234, "capture");
        rd_chk(`TMRSEG_OFF_STS, 32'h0000_0202, "sts ovc");
        wr(`TMRSEG_OFF_STS, 32'h0000_02A3);
        // The interrupt register drops at the clearing edge; look one edge later
        @(posedge pclk);
        `CHK("irq clr", 1'b0, irq)
        // Control update without and with complementary outputs
        for (int c = 0; c < 2; c++) begin
            wr(`TMRSEG_OFF_CTRL, (c == 0) ? 32'h0000_0001 : 32'h0000_0041);
            fire(16'h0020);
            `CHK("ctl pulse", 8'(c), n_ctl)
            rd_chk(`TMRSEG_OFF_STS, (c == 0) ? 32'h0 : 32'h0000_0020, "sts ctl");
            wr(`TMRSEG_OFF_STS, 32'h0000_02A3);
        end
        // Break event raises the interrupt through its mask bit
        wr(`TMRSEG_OFF_MSK, 32'h0000_0080);
        fire(16'h0080);
        `CHK("brk pulse", 8'h01, n_brk)
        rd_chk(`TMRSEG_OFF_STS, 32'h0000_0080, "sts brk");
        `CHK("irq brk", 1'b1, irq)
        wr(`TMRSEG_OFF_STS, 32'h0000_02A3);
        // Reserved positions and zero bits must do nothing
        fire(16'hFF5C);
        `CHK("rsv events", 32'h0, {n_upd, n_ctl, n_brk, n_dma})
        rd_chk(`TMRSEG_OFF_STS, 32'h0000_0000, "sts rsv");
        // Centre-aligned mode: a forced update clears the loaded down count
        wr(`TMRSEG_OFF_CTRL, 32'h0000_0002);
        fire(16'h0001);
        `CHK("upd centre", 8'h01, n_upd)
        rd_chk(`TMRSEG_OFF_CNT, 32'h0000_0000, "cnt centre");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
